//--- hw/tsw_pkg.sv
package tsw_pkg;

    // ------------------------------------------------------------
    // register map (byte addresses on the apb bus)
    // ------------------------------------------------------------
    localparam logic [7:0] TSW_OFF_DATA   = 8'h00;
    localparam logic [7:0] TSW_OFF_ADDR   = 8'h04;
    localparam logic [7:0] TSW_OFF_CMD    = 8'h08;
    localparam logic [7:0] TSW_OFF_SUBSEL = 8'h0c;
    localparam logic [7:0] TSW_OFF_STATUS = 8'h10;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] TSW_RST_DATA   = 8'h00;
    localparam logic [7:0] TSW_RST_ADDR   = 8'h00;
    localparam logic [7:0] TSW_RST_CMD    = 8'h00;
    localparam logic [7:0] TSW_RST_SUBSEL = 8'h00;
    localparam logic [3:0] TSW_RST_TRI    = 4'h0;

    // ------------------------------------------------------------
    // command register fields
    // ------------------------------------------------------------
    localparam int TSW_CMD_OP_LSB   = 4;
    localparam int TSW_CMD_CODE_LSB = 0;
    localparam int TSW_ADDR_DIR_BIT = 7;
    localparam int TSW_PTR_DIR_BIT  = 7;

    localparam logic [3:0] TSW_OP_TRISTATE = 4'h6;
    localparam logic [3:0] TSW_OP_CM_WRITE = 4'h7;

    // ------------------------------------------------------------
    // switching codes
    // ------------------------------------------------------------
    localparam logic [3:0] TSW_CODE_UNASSIGNED = 4'h0;
    localparam logic [3:0] TSW_CODE_64K        = 4'h1;
    localparam logic [3:0] TSW_CODE_32K_LOW    = 4'h2;
    localparam logic [3:0] TSW_CODE_32K_HIGH   = 4'h3;
    localparam logic [3:0] TSW_CODE_16K_B10    = 4'h4;
    localparam logic [3:0] TSW_CODE_16K_B32    = 4'h5;
    localparam logic [3:0] TSW_CODE_16K_B54    = 4'h6;
    localparam logic [3:0] TSW_CODE_16K_B76    = 4'h7;

    // ------------------------------------------------------------
    // per-port sub-channel placement selections
    // ------------------------------------------------------------
    localparam logic [1:0] TSW_SEL_HIGH = 2'b00;
    localparam logic [1:0] TSW_SEL_MID  = 2'b01;
    localparam logic [1:0] TSW_SEL_ALT  = 2'b10;
    localparam logic [1:0] TSW_SEL_LOW  = 2'b11;

    localparam logic [7:0] TSW_IDLE_BYTE = 8'hff;

endpackage : tsw_pkg

//--- hw/tsw_fifo.sv
module tsw_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    // clock and reset
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    // filling side
    input  wire logic                       in_valid,
    output logic                            in_ready,
    input  wire logic [WIDTH-1:0]           in_data,
    // draining side
    output logic                            out_valid,
    input  wire logic                       out_ready,
    output logic [WIDTH-1:0]                out_data,
    // fill level
    output logic [$clog2(DEPTH+1)-1:0]      level
);

    localparam int AW = $clog2(DEPTH);
    localparam int LW = $clog2(DEPTH+1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW-1:0]    next_wr_ptr;
    logic [AW-1:0]    next_rd_ptr;
    logic [LW-1:0]    next_level;
    logic             push;
    logic             pop;

    assign in_ready  = (level != LW'(DEPTH));
    assign out_valid = (level != '0);
    assign out_data  = mem[rd_ptr];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb
    begin
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        next_level  = level;
        if (push)
        begin
            next_wr_ptr = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
        end
        if (pop)
        begin
            next_rd_ptr = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
        end
        if (push && !pop)
        begin
            next_level = level + 1'b1;
        end
        else if (pop && !push)
        begin
            next_level = level - 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            level  <= '0;
        end
        else
        begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            level  <= next_level;
        end
    end

    // storage carries no reset: only entries counted by level are read
    always_ff @(posedge pclk)
    begin
        if (push)
        begin
            mem[wr_ptr] <= in_data;
        end
    end

endmodule : tsw_fifo

//--- hw/tsw_switch.sv
// What this block does
// - loops join slots or sub-slots of one interface, no external wiring
// - loops pass through the opposite interface's spare slot
// - borrowed pcm slot can be held at high impedance
// - tristate low-z drives looped data on pcm output, high-z hides it
// - downstream pointer with top bit 1 reads upstream data memory
// - code 0000 marks downstream output unassigned, others keep it active
// - upstream pointer top bit 0 feeds internal downstream byte, not pin
// - command 0110 0000 writes tristate field of addressed pcm slot
// - tristate bits 3..0 control pairs 7-6..1-0; 1 is low impedance
// - codes 0100, 0110, 0111 select two-bit pcm bits 1-0, 5-4, 7-6
// - code 0011 selects four-bit pcm upper nibble 7-4
// - code 0001 connects all eight bits
// - port select 11, 01, 10 places line sub-channels as tabled
// - sub-channel select register 8 bits, reset zero, port n at 2n+1:2n
module tsw_switch
    import tsw_pkg::*;
#(
    parameter int SLOTS      = 128,
    parameter int FIFO_DEPTH = 4
) (
    // clock and reset
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    // apb slave
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [7:0]           paddr,
    input  wire logic [31:0]          pwdata,
    output logic                      pready,
    output logic [31:0]               prdata,
    output logic                      pslverr,
    // upstream line input, one byte per line slot
    input  wire logic                 up_in_valid,
    input  wire logic [6:0]           up_in_slot,
    input  wire logic [7:0]           up_in_data,
    // downstream pcm input, one byte per pcm slot
    input  wire logic                 pcm_in_valid,
    input  wire logic [6:0]           pcm_in_slot,
    input  wire logic [7:0]           pcm_in_data,
    // downstream line output stream
    output logic                      dn_out_valid,
    input  wire logic                 dn_out_ready,
    output logic [6:0]                dn_out_slot,
    output logic [7:0]                dn_out_data,
    output logic                      dn_out_active,
    // pcm transmit output with per-bit drive enables
    output logic                      pcm_tx_valid,
    output logic [6:0]                pcm_tx_slot,
    output logic [7:0]                pcm_tx_data,
    output logic [7:0]                pcm_tx_oe
);

    localparam int FW = 16;
    localparam int LW = $clog2(FIFO_DEPTH+1);

    // ------------------------------------------------------------
    // sub-channel geometry
    // ------------------------------------------------------------
    function automatic logic [3:0] code_width(input logic [3:0] code);
        logic [3:0] w;
        w = 4'h0;
        unique case (code)
            TSW_CODE_64K:                        w = 4'h8;
            TSW_CODE_32K_HIGH, TSW_CODE_32K_LOW: w = 4'h4;
            TSW_CODE_16K_B10, TSW_CODE_16K_B32,
            TSW_CODE_16K_B54, TSW_CODE_16K_B76:  w = 4'h2;
            default:                             w = 4'h0;
        endcase
        return w;
    endfunction : code_width

    function automatic logic [2:0] pcm_offset(input logic [3:0] code);
        logic [2:0] o;
        o = 3'h0;
        unique case (code)
            TSW_CODE_32K_HIGH: o = 3'h4;
            TSW_CODE_16K_B76:  o = 3'h6;
            TSW_CODE_16K_B54:  o = 3'h4;
            TSW_CODE_16K_B32:  o = 3'h2;
            default:           o = 3'h0;
        endcase
        return o;
    endfunction : pcm_offset

    function automatic logic [2:0] line_offset(input logic [1:0] sel,
                                               input logic [3:0] w);
        logic [2:0] o;
        o = 3'h0;
        if (w == 4'h4)
        begin
            o = (sel == TSW_SEL_HIGH || sel == TSW_SEL_ALT) ? 3'h4 : 3'h0;
        end
        else if (w == 4'h2)
        begin
            unique case (sel)
                TSW_SEL_HIGH: o = 3'h6;
                TSW_SEL_MID:  o = 3'h4;
                TSW_SEL_ALT:  o = 3'h2;
                TSW_SEL_LOW:  o = 3'h0;
            endcase
        end
        return o;
    endfunction : line_offset

    // copies w bits of src starting at soff into dst starting at doff
    function automatic logic [7:0] place(input logic [7:0] dst,
                                         input logic [7:0] src,
                                         input logic [2:0] soff,
                                         input logic [2:0] doff,
                                         input logic [3:0] w);
        logic [7:0] r;
        logic [3:0] k;
        r = dst;
        for (int i = 0; i < 8; i++)
        begin
            k = 4'(i) - {1'b0, doff};
            if (4'(i) >= {1'b0, doff} && k < w)
            begin
                r[i] = src[3'(k + {1'b0, soff})];
            end
        end
        return r;
    endfunction : place

    // ------------------------------------------------------------
    // apb registers
    // ------------------------------------------------------------
    logic [7:0]    data_reg;
    logic [7:0]    addr_reg;
    logic [7:0]    cmd_reg;
    logic [7:0]    subsel_reg;
    logic [7:0]    next_data_reg;
    logic [7:0]    next_addr_reg;
    logic [7:0]    next_cmd_reg;
    logic [7:0]    next_subsel_reg;
    logic [31:0]   next_prdata;
    logic          next_pslverr;
    logic          wr_access;
    logic          setup;
    logic          mapped;
    logic [6:0]    slot_cnt;
    logic [LW-1:0] fifo_level;

    assign wr_access = psel && penable && pwrite && pready;
    assign setup     = psel && !penable;
    assign mapped    = (paddr == TSW_OFF_DATA) || (paddr == TSW_OFF_ADDR) ||
                       (paddr == TSW_OFF_CMD) || (paddr == TSW_OFF_SUBSEL) ||
                       (paddr == TSW_OFF_STATUS);

    always_comb
    begin
        next_data_reg   = data_reg;
        next_addr_reg   = addr_reg;
        next_cmd_reg    = cmd_reg;
        next_subsel_reg = subsel_reg;
        next_prdata     = prdata;
        next_pslverr    = pslverr;
        if (wr_access)
        begin
            unique case (paddr)
                TSW_OFF_DATA:   next_data_reg   = pwdata[7:0];
                TSW_OFF_ADDR:   next_addr_reg   = pwdata[7:0];
                TSW_OFF_CMD:    next_cmd_reg    = pwdata[7:0];
                TSW_OFF_SUBSEL: next_subsel_reg = pwdata[7:0];
                default:        ;
            endcase
        end
        // read data and error are prepared in the setup cycle so that
        // the access phase completes with zero wait states
        if (setup)
        begin
            next_pslverr = !mapped;
            unique case (paddr)
                TSW_OFF_DATA:   next_prdata = {24'h0, data_reg};
                TSW_OFF_ADDR:   next_prdata = {24'h0, addr_reg};
                TSW_OFF_CMD:    next_prdata = {24'h0, cmd_reg};
                TSW_OFF_SUBSEL: next_prdata = {24'h0, subsel_reg};
                TSW_OFF_STATUS: next_prdata = {21'h0, 4'(fifo_level),
                                               slot_cnt};
                default:        next_prdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            data_reg   <= TSW_RST_DATA;
            addr_reg   <= TSW_RST_ADDR;
            cmd_reg    <= TSW_RST_CMD;
            subsel_reg <= TSW_RST_SUBSEL;
            prdata     <= 32'h0;
            pslverr    <= 1'b0;
            pready     <= 1'b0;
        end
        else
        begin
            data_reg   <= next_data_reg;
            addr_reg   <= next_addr_reg;
            cmd_reg    <= next_cmd_reg;
            subsel_reg <= next_subsel_reg;
            prdata     <= next_prdata;
            pslverr    <= next_pslverr;
            pready     <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // memory commands
    // ------------------------------------------------------------
    // the entry is built from data and address already held, so the
    // command write alone commits it in one edge
    logic [11:0] up_cm [SLOTS];
    logic [11:0] dn_cm [SLOTS];
    logic [3:0]  tri_mem [SLOTS];
    logic [7:0]  up_dm [SLOTS];
    logic [7:0]  dn_dm [SLOTS];
    logic        cmd_go;
    logic [3:0]  cmd_op;
    logic        cm_we_up;
    logic        cm_we_dn;
    logic        tri_we;
    logic [11:0] cm_entry;

    assign cmd_go   = wr_access && (paddr == TSW_OFF_CMD);
    assign cmd_op   = pwdata[TSW_CMD_OP_LSB +: 4];
    assign cm_entry = {pwdata[TSW_CMD_CODE_LSB +: 4], data_reg};
    assign cm_we_up = cmd_go && cmd_op == TSW_OP_CM_WRITE &&
                      addr_reg[TSW_ADDR_DIR_BIT];
    assign cm_we_dn = cmd_go && cmd_op == TSW_OP_CM_WRITE &&
                      !addr_reg[TSW_ADDR_DIR_BIT];
    assign tri_we   = cmd_go && cmd_op == TSW_OP_TRISTATE;

    // whole-entry writes in one edge; readers see either old or new
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < SLOTS; i++)
            begin
                up_cm[i]   <= {TSW_CODE_UNASSIGNED, 8'h00};
                dn_cm[i]   <= {TSW_CODE_UNASSIGNED, 8'h00};
                tri_mem[i] <= TSW_RST_TRI;
            end
        end
        else
        begin
            if (cm_we_up)
            begin
                up_cm[addr_reg[6:0]] <= cm_entry;
            end
            if (cm_we_dn)
            begin
                dn_cm[addr_reg[6:0]] <= cm_entry;
            end
            if (tri_we)
            begin
                tri_mem[addr_reg[6:0]] <= data_reg[3:0];
            end
        end
    end

    // ------------------------------------------------------------
    // downstream line byte for a line slot
    // ------------------------------------------------------------
    // a pointer with the direction bit set reads the upstream store,
    // which is how a line-to-line loop returns through the pcm side
    function automatic logic [8:0] line_byte(input logic [11:0] ent,
                                             input logic [7:0]  up_b,
                                             input logic [7:0]  dn_b,
                                             input logic [1:0]  sel);
        logic [7:0] src;
        logic [3:0] w;
        src = ent[TSW_PTR_DIR_BIT] ? up_b : dn_b;
        w   = code_width(ent[11:8]);
        return {ent[11:8] != TSW_CODE_UNASSIGNED,
                place(TSW_IDLE_BYTE, src, pcm_offset(ent[11:8]),
                      line_offset(sel, w), w)};
    endfunction : line_byte

    function automatic logic [1:0] port_sel(input logic [7:0] sub,
                                            input logic [6:0] slot);
        return sub[{slot[1:0], 1'b0} +: 2];
    endfunction : port_sel

    // ------------------------------------------------------------
    // upstream and downstream data memory capture
    // ------------------------------------------------------------
    logic [11:0] up_ent;
    logic [11:0] lp_ent;
    logic [8:0]  lp_byte;
    logic [7:0]  up_src;
    logic [3:0]  up_w;
    logic [1:0]  up_sel;
    logic        up_we;

    assign up_ent  = up_cm[up_in_slot];
    assign lp_ent  = dn_cm[up_in_slot];
    assign up_sel  = port_sel(subsel_reg, up_in_slot);
    assign lp_byte = line_byte(lp_ent, up_dm[lp_ent[6:0]],
                               dn_dm[lp_ent[6:0]], up_sel);
    // top bit 0 loops the internal downstream byte back upstream
    assign up_src  = up_ent[TSW_PTR_DIR_BIT] ? up_in_data
                                             : lp_byte[7:0];
    assign up_w    = code_width(up_ent[11:8]);
    assign up_we   = up_in_valid && up_w != 4'h0;

    always_ff @(posedge pclk)
    begin
        if (up_we)
        begin
            up_dm[up_ent[6:0]] <= place(up_dm[up_ent[6:0]], up_src,
                                        line_offset(up_sel, up_w),
                                        pcm_offset(up_ent[11:8]),
                                        up_w);
        end
        if (pcm_in_valid)
        begin
            dn_dm[pcm_in_slot] <= pcm_in_data;
        end
    end

    // ------------------------------------------------------------
    // slot sequencer and output stage
    // ------------------------------------------------------------
    // the sequencer stalls while the output fifo is full, so a slow
    // line receiver holds back slot generation instead of losing bytes
    logic [11:0]   seq_ent;
    logic [8:0]    seq_byte;
    logic          fifo_in_ready;
    logic [FW-1:0] fifo_out;
    logic          fifo_out_valid;
    logic [6:0]    next_slot_cnt;
    logic          next_pcm_tx_valid;
    logic [6:0]    next_pcm_tx_slot;
    logic [7:0]    next_pcm_tx_data;
    logic [7:0]    next_pcm_tx_oe;
    logic [7:0]    oe_bits;

    assign seq_ent  = dn_cm[slot_cnt];
    assign seq_byte = line_byte(seq_ent, up_dm[seq_ent[6:0]],
                                dn_dm[seq_ent[6:0]],
                                port_sel(subsel_reg, slot_cnt));

    generate
        for (genvar p = 0; p < 4; p++)
        begin : g_pair
            assign oe_bits[2*p+1 -: 2] = {2{tri_mem[slot_cnt][p]}};
        end
    endgenerate

    always_comb
    begin
        next_slot_cnt     = slot_cnt;
        next_pcm_tx_valid = 1'b0;
        next_pcm_tx_slot  = pcm_tx_slot;
        next_pcm_tx_data  = pcm_tx_data;
        next_pcm_tx_oe    = pcm_tx_oe;
        if (fifo_in_ready)
        begin
            next_slot_cnt     = (slot_cnt == 7'(SLOTS - 1)) ? 7'h0
                                                            : slot_cnt + 7'h1;
            next_pcm_tx_valid = 1'b1;
            next_pcm_tx_slot  = slot_cnt;
            next_pcm_tx_data  = up_dm[slot_cnt];
            next_pcm_tx_oe    = oe_bits;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            slot_cnt     <= 7'h0;
            pcm_tx_valid <= 1'b0;
            pcm_tx_slot  <= 7'h0;
            pcm_tx_data  <= TSW_IDLE_BYTE;
            pcm_tx_oe    <= 8'h00;
        end
        else
        begin
            slot_cnt     <= next_slot_cnt;
            pcm_tx_valid <= next_pcm_tx_valid;
            pcm_tx_slot  <= next_pcm_tx_slot;
            pcm_tx_data  <= next_pcm_tx_data;
            pcm_tx_oe    <= next_pcm_tx_oe;
        end
    end

    tsw_fifo #(
        .WIDTH (FW),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .pclk      (pclk),
        .presetn   (presetn),
        .in_valid  (1'b1),
        .in_ready  (fifo_in_ready),
        .in_data   ({slot_cnt, seq_byte}),
        .out_valid (fifo_out_valid),
        .out_ready (dn_out_ready),
        .out_data  (fifo_out),
        .level     (fifo_level)
    );

    assign dn_out_valid  = fifo_out_valid;
    assign dn_out_slot   = fifo_out[15:9];
    assign dn_out_active = fifo_out[8];
    assign dn_out_data   = fifo_out[7:0];

endmodule : tsw_switch

//--- tb/tsw_switch_chk.sv
module tsw_switch_chk (
    // watched ports
    input wire logic       pclk, presetn, psel, penable, pready, pslverr,
    input wire logic [7:0] paddr, pcm_tx_oe, dn_out_data,
    input wire logic       pcm_tx_valid, dn_out_valid, dn_out_ready,
    input wire logic       dn_out_active,
    input wire logic [6:0] pcm_tx_slot, dn_out_slot
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // six idle edges let at most four pushes land
    sequence s_blocked;
        !dn_out_ready [*6];
    endsequence
    a_no_wait: assert property ($past(presetn) |-> pready)
        else $error("pready low");
    a_bad_addr: assert property (psel && penable
        && paddr > 8'h10 |-> pslverr) else $error("no error on bad address");
    a_good_addr: assert property (psel && penable && paddr < 8'h14
        && paddr[1:0] == 2'h0 |-> !pslverr) else $error("error on register");
    a_oe_pairs: assert property (pcm_tx_oe == {{2{pcm_tx_oe[7]}},
        {2{pcm_tx_oe[5]}}, {2{pcm_tx_oe[3]}}, {2{pcm_tx_oe[1]}}})
        else $error("drive enable pair split");
    a_idle_ff: assert property (dn_out_valid && !dn_out_active
        |-> dn_out_data == 8'hff) else $error("idle byte not ff");
    a_fifo_hold: assert property (dn_out_valid && !dn_out_ready |=>
        dn_out_valid && $stable(dn_out_slot) && $stable(dn_out_data))
        else $error("line byte changed while stalled");
    a_full_stall: assert property (s_blocked |-> !pcm_tx_valid)
        else $error("sequencer ran past full fifo");
    a_slot_order: assert property (pcm_tx_valid && $past(pcm_tx_valid)
        |-> pcm_tx_slot == $past(pcm_tx_slot) + 7'h01)
        else $error("pcm slot skipped");
endmodule : tsw_switch_chk

bind tsw_switch tsw_switch_chk chk_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
    .paddr(paddr), .pcm_tx_oe(pcm_tx_oe), .dn_out_data(dn_out_data),
    .pcm_tx_valid(pcm_tx_valid), .dn_out_valid(dn_out_valid),
    .dn_out_ready(dn_out_ready), .dn_out_active(dn_out_active),
    .pcm_tx_slot(pcm_tx_slot), .dn_out_slot(dn_out_slot));

//--- tb/tsw_far_end.sv
module tsw_far_end (
    // clock and stall request
    input  wire logic       pclk,
    input  wire logic       hold,
    // line and pcm bytes, downstream sink
    output logic            up_in_valid,
    output logic            pcm_in_valid,
    output logic [6:0]      up_in_slot,
    output logic [6:0]      pcm_in_slot,
    output logic [7:0]      up_in_data,
    output logic [7:0]      pcm_in_data,
    output logic            dn_out_ready
);
    timeunit 1ns;
    timeprecision 100ps;
    integer ps = 78189;
    initial {up_in_valid, pcm_in_valid, dn_out_ready} = 3'h0;
    initial {up_in_slot, pcm_in_slot, up_in_data, pcm_in_data} = '0;
    // random drain rate so the fifo sees slow and fast sinks
    always @(posedge pclk)
        dn_out_ready <= !hold & 1'($random(ps));
    task automatic send(input bit pcm, input logic [6:0] s,
                        input logic [7:0] d);
        @(posedge pclk);
        up_in_valid  <= !pcm;
        pcm_in_valid <= pcm;
        {up_in_slot, pcm_in_slot, up_in_data, pcm_in_data} <= {s, s, d, d};
        @(posedge pclk);
        {up_in_valid, pcm_in_valid} <= 2'h0;
        // released lines show the inverse, never the stale byte
        {up_in_data, pcm_in_data} <= {~d, ~d};
    endtask : send
endmodule : tsw_far_end

//--- tb/timeslot_loop_subchannel_switch_test.sv
module timeslot_loop_subchannel_switch_test;
    timeunit 1ns;
    timeprecision 100ps;
    import tsw_pkg::*;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic        hold = 0, pready, pslverr, e, up_v, pcm_v, dn_v, dn_r, da;
    logic [7:0]  paddr = '0, up_d, pcm_d, dn_d, tx_d, oe, sub, d, ep, x, o;
    logic [6:0]  up_s, pcm_s, dn_s, tx_s;
    logic [31:0] pwdata = '0, prdata, r;
    logic        tx_v;
    integer      seed = 78189;
    int          err_count = 0, n_compared = 0;
    always #12.5 pclk = ~pclk;
    tsw_switch dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .up_in_valid(up_v), .up_in_slot(up_s), .up_in_data(up_d),
        .pcm_in_valid(pcm_v), .pcm_in_slot(pcm_s), .pcm_in_data(pcm_d),
        .dn_out_valid(dn_v), .dn_out_ready(dn_r), .dn_out_slot(dn_s),
        .dn_out_data(dn_d), .dn_out_active(da), .pcm_tx_valid(tx_v),
        .pcm_tx_slot(tx_s), .pcm_tx_data(tx_d), .pcm_tx_oe(oe));
    tsw_far_end far (.pclk(pclk), .hold(hold), .up_in_valid(up_v),
        .pcm_in_valid(pcm_v), .up_in_slot(up_s), .pcm_in_slot(pcm_s),
        .up_in_data(up_d), .pcm_in_data(pcm_d), .dn_out_ready(dn_r));
    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : end_of_test
    task automatic chk(input string n, input logic [31:0] s, xp);
        n_compared++;
        if (s !== xp)
        begin
            $display("ERROR %s expected %h seen %h", n, xp, s);
            err_count++;
        end
    endtask : chk
    task automatic bus(input logic w, input logic [7:0] a, wd);
        int n = 0;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, 24'h0, wd};
        @(posedge pclk);
        penable <= 1;
        // read data and pready are taken at the edge that ends the access
        do @(posedge pclk); while (pready !== 1'b1 && ++n < 50);
        {r, e} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
        if (n == 50)
        begin
            err_count++;
            end_of_test();
        end
    endtask : bus
    task automatic prog(input logic [7:0] dv, av, cv);
        bus(1, TSW_OFF_DATA, dv);
        bus(1, TSW_OFF_ADDR, av);
        bus(1, TSW_OFF_CMD, cv);
    endtask : prog
    // second sighting: the first may predate the new entry
    task automatic hit(input bit dn, input logic [6:0] s);
        int n, k;
        k = 0;
        for (n = 0; n < 3000 && k < 2; n++)
        begin
            @(posedge pclk);
            k += (dn ? dn_v === 1 && dn_r === 1 && dn_s === s
                     : tx_v === 1 && tx_s === s);
        end
        {x, o} = dn ? {dn_d, 7'h0, da} : {tx_d, oe};
        if (k < 2)
        begin
            err_count++;
            end_of_test();
        end
    endtask : hit
    function automatic logic [7:0] merge(logic [7:0] old, src,
                                         logic [3:0] c, logic [1:0] s);
        int w, so, po;
        logic [7:0] m;
        w  = (c == 1) ? 8 : (c < 4) ? 4 : 2;
        po = (c < 3) ? 0 : (c == 3) ? 4 : 2 * (c - 4);
        so = (w == 8) ? 0 : (w == 4) ? (s[0] ? 0 : 4) : 6 - 2 * s;
        m  = 8'((1 << w) - 1);
        return (old & ~(m << po)) | (((src >> so) & m) << po);
    endfunction : merge
    initial
    begin
        repeat (6) @(posedge pclk);
        presetn <= 1;
        bus(0, TSW_OFF_SUBSEL, 0);
        chk("subsel reset", r, 32'(TSW_RST_SUBSEL));
        sub = 8'($random(seed));
        bus(1, TSW_OFF_SUBSEL, sub);
        bus(0, TSW_OFF_SUBSEL, 0);
        chk("subsel", r, 32'(sub));
        bus(0, 8'h14, 0);
        chk("unmapped", {r[30:0], e}, 1);
        for (int c = 1; c < 8; c++)
        begin
            d = 8'($random(seed));
            prog(8'hff, 8'h85, {TSW_OP_CM_WRITE, 4'(c)});
            far.send(0, 7'h05, d);
            ep = merge(ep, d, 4'(c), sub[3:2]);
            hit(0, 7'h7f);
            chk("pcm subchannel", x, ep);
        end
        for (int i = 0; i < 3; i++)
        begin
            d = (i == 0) ? 8'h0 : (i == 1) ? 8'h0f : 8'($random(seed)) & 8'h0f;
            prog(d, 8'hff, {TSW_OP_TRISTATE, 4'h0});
            hit(0, 7'h7f);
            chk("drive", o, {{2{d[3]}}, {2{d[2]}},
                             {2{d[1]}}, {2{d[0]}}});
            chk("borrowed slot", x, ep);
        end
        prog(8'hff, 8'h0a, {TSW_OP_CM_WRITE, TSW_CODE_64K});
        hit(1, 7'h0a);
        chk("line loop", {o, x}, {8'h1, ep});
        prog(8'hff, 8'h0a, {TSW_OP_CM_WRITE, TSW_CODE_UNASSIGNED});
        hit(1, 7'h0a);
        chk("unassigned", {o, x}, {8'h0, TSW_IDLE_BYTE});
        d = 8'($random(seed));
        prog(8'h20, 8'h10, {TSW_OP_CM_WRITE, TSW_CODE_64K});
        prog(8'h30, 8'h90, {TSW_OP_CM_WRITE, TSW_CODE_64K});
        far.send(1, 7'h20, d);
        far.send(0, 7'h10, ~d);
        hit(0, 7'h30);
        chk("pcm loop", x, d);
        hold <= 1;
        repeat (8) @(posedge pclk);
        bus(0, TSW_OFF_STATUS, 0);
        chk("fifo full", r[10:7], 4);
        hold <= 0;
        end_of_test();
    end
endmodule : timeslot_loop_subchannel_switch_test
